// ---- verilog/adcr_pkg.sv ----
package adcr_pkg;
  localparam int DATA_W = 16;
  localparam int FIELD_W = 12;
  localparam int CRC_W = 8;
  localparam int WORD_W = 2 * DATA_W;
  localparam int WFRAME_W = DATA_W + CRC_W;
  localparam int TXA_W = WORD_W + CRC_W;
  localparam int CNT_W = 6;
  localparam int LIMIT_LSB = DATA_W - FIELD_W;
  localparam logic [CRC_W:0] CRC_POLY = 9'h107;
  localparam logic [CRC_W-1:0] CRC_INIT = 8'hff;
  localparam int CMD_WR_BIT = 15;
  localparam int CMD_ADDR_LSB = 12;
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] REG_PRIMARY = 3'h1;
  localparam logic [ADDR_W-1:0] REG_SECONDARY = 3'h2;
  localparam logic [ADDR_W-1:0] REG_ALERT = 3'h3;
  localparam logic [ADDR_W-1:0] REG_LOWER = 3'h4;
  localparam logic [ADDR_W-1:0] REG_UPPER = 3'h5;
  localparam logic [FIELD_W-1:0] PRIMARY_RST = 12'h000;
  localparam logic [FIELD_W-1:0] SECONDARY_RST = 12'h000;
  localparam logic [FIELD_W-1:0] FLAGS_RST = 12'h000;
  localparam logic [FIELD_W-1:0] LOWER_RST = 12'h000;
  localparam logic [FIELD_W-1:0] UPPER_RST = 12'hfff;
  localparam int P_WCRC = 5;
  localparam int P_RCRC = 4;
  localparam int P_ALERT = 3;
  localparam int S_LANE = 8;
  localparam int F_WFAIL = 9;
  localparam int F_B_OVER = 5;
  localparam int F_B_UNDER = 4;
  localparam int F_A_OVER = 1;
  localparam int F_A_UNDER = 0;
  localparam int AVS_AW = 5;
  localparam int AVS_DW = 32;
  localparam logic [AVS_AW-1:0] HOFF_CMD = 5'h00;
  localparam logic [AVS_AW-1:0] HOFF_CFG = 5'h04;
  localparam logic [AVS_AW-1:0] HOFF_RXA = 5'h08;
  localparam logic [AVS_AW-1:0] HOFF_RXB = 5'h0c;
  localparam logic [AVS_AW-1:0] HOFF_RXCRC = 5'h10;
  localparam logic [AVS_AW-1:0] HOFF_STATUS = 5'h14;
  localparam logic [AVS_AW-1:0] HOFF_MASK = 5'h18;
  localparam int CFG_W = 3;
  localparam int C_WCRC = 0;
  localparam int C_RCRC = 1;
  localparam int C_ONE = 2;
  localparam int ST_W = 2;
  localparam int ST_DONE = 0;
  localparam int ST_CRCERR = 1;
  localparam int ST_BUSY = 8;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage

// ---- verilog/adcr_link_if.sv ----
`timescale 1ns/100ps
interface adcr_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic lane_a_out;
  logic lane_a_oe;
  logic lane_b_out;
  logic lane_b_oe;
  modport dev (input cs_n, sclk, sdi,
    output lane_a_out, lane_a_oe, lane_b_out, lane_b_oe);
  modport host (output cs_n, sclk, sdi,
    input lane_a_out, lane_a_oe, lane_b_out, lane_b_oe);
endinterface

// ---- verilog/adcr_crc.sv ----
`timescale 1ns/100ps
module adcr_crc #(
  parameter int WIDTH = adcr_pkg::WORD_W
) (
  input wire logic [WIDTH-1:0] data_in,
  output logic [adcr_pkg::CRC_W-1:0] crc_out
);
  logic fb;

  // All-ones preload equals inverting the top byte; shifting every data
  // bit through the register stands for the eight appended zeros
  always_comb begin
    fb = 1'b0;
    crc_out = adcr_pkg::CRC_INIT;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      fb = crc_out[adcr_pkg::CRC_W-1] ^ data_in[i];
      crc_out = {crc_out[adcr_pkg::CRC_W-2:0], 1'b0}
        ^ (fb ? adcr_pkg::CRC_POLY[adcr_pkg::CRC_W-1:0] : '0);
    end
  end
endmodule

// ---- verilog/adcr_device.sv ----
`timescale 1ns/100ps
module adcr_device (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  adcr_link_if.dev link,
  input wire logic [adcr_pkg::DATA_W-1:0] chan_a_in,
  input wire logic [adcr_pkg::DATA_W-1:0] chan_b_in,
  output logic [adcr_pkg::FIELD_W-1:0] primary_config_out,
  output logic [adcr_pkg::FIELD_W-1:0] secondary_config_out
);
  localparam int DW = adcr_pkg::DATA_W;
  localparam int FW = adcr_pkg::FIELD_W;
  localparam int CW = adcr_pkg::CRC_W;
  localparam int RW = adcr_pkg::WFRAME_W;
  localparam int TW = adcr_pkg::TXA_W;
  localparam int NW = adcr_pkg::CNT_W;
  localparam int LL = adcr_pkg::LIMIT_LSB;

  logic [2:0] cs_sync_reg;
  logic [2:0] sclk_sync_reg;
  logic [1:0] sdi_sync_reg;

  logic active_reg, active_next;
  logic [RW-1:0] rx_sr_reg, rx_sr_next;
  logic [NW-1:0] bit_cnt_reg, bit_cnt_next;
  logic [TW-1:0] tx_a_reg, tx_a_next;
  logic [DW-1:0] tx_b_reg, tx_b_next;
  logic [DW-1:0] conv_a_reg, conv_a_next;
  logic [DW-1:0] conv_b_reg, conv_b_next;
  logic rd_pend_reg, rd_pend_next;
  logic [adcr_pkg::ADDR_W-1:0] rd_addr_reg, rd_addr_next;
  logic [FW-1:0] primary_reg, primary_next;
  logic [FW-1:0] secondary_reg, secondary_next;
  logic [FW-1:0] lower_reg, lower_next;
  logic [FW-1:0] upper_reg, upper_next;
  logic [FW-1:0] flags_reg, flags_next;

  logic cs_fall, cs_rise, sclk_rise, sclk_fall;
  logic one_wire, rx_long, frame_ok, crc_ok, cmd_wr;
  logic [FW-1:0] reg_field;
  logic [2*DW-1:0] out_word;
  logic [CW-1:0] out_crc, crc_field, cmd_crc;
  logic [DW-1:0] cmd;
  logic [adcr_pkg::ADDR_W-1:0] cmd_addr;

  // Link pins come from another domain: two stages before any use
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cs_sync_reg <= 3'h7;
      sclk_sync_reg <= 3'h0;
      sdi_sync_reg <= 2'h0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], link.cs_n};
      sclk_sync_reg <= {sclk_sync_reg[1:0], link.sclk};
      sdi_sync_reg <= {sdi_sync_reg[0], link.sdi};
    end
  end

  assign cs_fall = cs_sync_reg[2] & ~cs_sync_reg[1];
  assign cs_rise = ~cs_sync_reg[2] & cs_sync_reg[1];
  assign sclk_rise = ~sclk_sync_reg[2] & sclk_sync_reg[1];
  assign sclk_fall = sclk_sync_reg[2] & ~sclk_sync_reg[1];
  assign one_wire = secondary_reg[adcr_pkg::S_LANE];

  always_comb begin
    case (rd_addr_reg)
      adcr_pkg::REG_PRIMARY: reg_field = primary_reg;
      adcr_pkg::REG_SECONDARY: reg_field = secondary_reg;
      adcr_pkg::REG_ALERT: reg_field = flags_reg;
      adcr_pkg::REG_LOWER: reg_field = lower_reg;
      adcr_pkg::REG_UPPER: reg_field = upper_reg;
      default: reg_field = '0;
    endcase
  end

  // Readback carries the address in its top nibble, write bit clear
  assign out_word = rd_pend_reg
    ? {1'b0, rd_addr_reg, reg_field, {DW{1'b0}}}
    : {conv_a_reg, conv_b_reg};

  adcr_crc #(.WIDTH(2 * DW)) u_out_crc (
    .data_in(out_word),
    .crc_out(out_crc)
  );

  assign crc_field = primary_reg[adcr_pkg::P_RCRC] ? out_crc : '0;

  // Only the first 24 bits of a frame are kept; longer frames clock
  // out read data while the host shifts zeros
  assign rx_long = bit_cnt_reg >= NW'(RW);
  assign frame_ok = rx_long || bit_cnt_reg == NW'(DW);
  assign cmd = rx_long ? rx_sr_reg[RW-1:CW] : rx_sr_reg[DW-1:0];
  assign cmd_wr = cmd[adcr_pkg::CMD_WR_BIT];
  assign cmd_addr = cmd[adcr_pkg::CMD_WR_BIT-1:adcr_pkg::CMD_ADDR_LSB];

  adcr_crc #(.WIDTH(2 * DW)) u_cmd_crc (
    .data_in({cmd, {DW{1'b0}}}),
    .crc_out(cmd_crc)
  );

  assign crc_ok = rx_long && cmd_crc == rx_sr_reg[CW-1:0];

  always_comb begin
    active_next = active_reg;
    rx_sr_next = rx_sr_reg;
    bit_cnt_next = bit_cnt_reg;
    tx_a_next = tx_a_reg;
    tx_b_next = tx_b_reg;
    conv_a_next = conv_a_reg;
    conv_b_next = conv_b_reg;
    rd_pend_next = rd_pend_reg;
    rd_addr_next = rd_addr_reg;
    primary_next = primary_reg;
    secondary_next = secondary_reg;
    lower_next = lower_reg;
    upper_next = upper_reg;
    flags_next = flags_reg;
    if (cs_fall) begin
      active_next = 1'b1;
      bit_cnt_next = '0;
      rx_sr_next = '0;
      rd_pend_next = 1'b0;
      // One-frame latency: previous sample goes out, new one is held
      if (one_wire) begin
        tx_a_next = {out_word, crc_field};
      end else begin
        tx_a_next = {out_word[2*DW-1:DW], crc_field, {DW{1'b0}}};
      end
      tx_b_next = rd_pend_reg ? '0 : out_word[DW-1:0];
      conv_a_next = chan_a_in;
      conv_b_next = chan_b_in;
      if (rd_pend_reg && rd_addr_reg == adcr_pkg::REG_ALERT) begin
        flags_next = '0;
      end
      // Flags set below win over the clear-on-read above
      if (primary_reg[adcr_pkg::P_ALERT]) begin
        if (chan_a_in[DW-1:LL] > upper_reg) begin
          flags_next[adcr_pkg::F_A_OVER] = 1'b1;
        end
        if (chan_a_in[DW-1:LL] < lower_reg) begin
          flags_next[adcr_pkg::F_A_UNDER] = 1'b1;
        end
        if (chan_b_in[DW-1:LL] > upper_reg) begin
          flags_next[adcr_pkg::F_B_OVER] = 1'b1;
        end
        if (chan_b_in[DW-1:LL] < lower_reg) begin
          flags_next[adcr_pkg::F_B_UNDER] = 1'b1;
        end
      end
    end else if (cs_rise) begin
      active_next = 1'b0;
      if (frame_ok && cmd_wr) begin
        if (primary_reg[adcr_pkg::P_WCRC] && !crc_ok) begin
          flags_next[adcr_pkg::F_WFAIL] = 1'b1;
        end else begin
          case (cmd_addr)
            adcr_pkg::REG_PRIMARY: primary_next = cmd[FW-1:0];
            adcr_pkg::REG_SECONDARY: secondary_next = cmd[FW-1:0];
            adcr_pkg::REG_LOWER: lower_next = cmd[FW-1:0];
            adcr_pkg::REG_UPPER: upper_next = cmd[FW-1:0];
            adcr_pkg::REG_ALERT: flags_next = flags_reg;
            default: flags_next = flags_reg;
          endcase
        end
      end else if (frame_ok) begin
        // Every defined register is readable; others fall back
        if (cmd_addr >= adcr_pkg::REG_PRIMARY
            && cmd_addr <= adcr_pkg::REG_UPPER) begin
          rd_pend_next = 1'b1;
          rd_addr_next = cmd_addr;
        end else begin
          rd_pend_next = 1'b0;
        end
      end
    end else if (active_reg) begin
      if (sclk_rise && !rx_long) begin
        rx_sr_next = {rx_sr_reg[RW-2:0], sdi_sync_reg[1]};
        bit_cnt_next = bit_cnt_reg + NW'(1);
      end
      if (sclk_fall) begin
        tx_a_next = {tx_a_reg[TW-2:0], 1'b0};
        tx_b_next = {tx_b_reg[DW-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      active_reg <= 1'b0;
      rx_sr_reg <= '0;
      bit_cnt_reg <= '0;
      tx_a_reg <= '0;
      tx_b_reg <= '0;
      conv_a_reg <= '0;
      conv_b_reg <= '0;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= '0;
      primary_reg <= adcr_pkg::PRIMARY_RST;
      secondary_reg <= adcr_pkg::SECONDARY_RST;
      lower_reg <= adcr_pkg::LOWER_RST;
      upper_reg <= adcr_pkg::UPPER_RST;
      flags_reg <= adcr_pkg::FLAGS_RST;
    end else begin
      active_reg <= active_next;
      rx_sr_reg <= rx_sr_next;
      bit_cnt_reg <= bit_cnt_next;
      tx_a_reg <= tx_a_next;
      tx_b_reg <= tx_b_next;
      conv_a_reg <= conv_a_next;
      conv_b_reg <= conv_b_next;
      rd_pend_reg <= rd_pend_next;
      rd_addr_reg <= rd_addr_next;
      primary_reg <= primary_next;
      secondary_reg <= secondary_next;
      lower_reg <= lower_next;
      upper_reg <= upper_next;
      flags_reg <= flags_next;
    end
  end

  assign link.lane_a_out = tx_a_reg[TW-1];
  assign link.lane_a_oe = active_reg;
  assign link.lane_b_out = tx_b_reg[DW-1];
  assign link.lane_b_oe = active_reg & ~one_wire;
  assign primary_config_out = primary_reg;
  assign secondary_config_out = secondary_reg;
endmodule

// ---- verilog/adcr_host.sv ----
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/100ps
module adcr_host #(
  parameter int HALF_CYC = adcr_pkg::SCLK_HALF_CYC,
  parameter int DIV_W = 8
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [adcr_pkg::AVS_AW-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [adcr_pkg::AVS_DW-1:0] avs_writedata_in,
  output logic [adcr_pkg::AVS_DW-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  adcr_link_if.host link
);
  localparam int DW = adcr_pkg::DATA_W;
  localparam int CW = adcr_pkg::CRC_W;
  localparam int RW = adcr_pkg::WFRAME_W;
  localparam int TW = adcr_pkg::TXA_W;
  localparam int NW = adcr_pkg::CNT_W;
  localparam int AW = adcr_pkg::AVS_DW;

  logic [1:0] lane_a_sync_reg, lane_b_sync_reg;
  logic [adcr_pkg::CFG_W-1:0] cfg_reg, cfg_next;
  logic [adcr_pkg::ST_W-1:0] mask_reg, mask_next, status_reg, status_next;
  logic [adcr_pkg::ST_W-1:0] st_set, st_clr;
  logic busy_reg, busy_next, cs_n_reg, cs_n_next, sclk_reg, sclk_next;
  logic [DIV_W-1:0] div_reg, div_next;
  logic [NW-1:0] done_reg, done_next, len_reg, len_next, rxl_reg, rxl_next;
  logic [RW-1:0] tx_sr_reg, tx_sr_next;
  logic [TW-1:0] rx_a_reg, rx_a_next;
  logic [DW-1:0] rx_b_reg, rx_b_next, res_a_reg, res_a_next;
  logic [DW-1:0] res_b_reg, res_b_next, cmd_reg, cmd_next;
  logic [CW-1:0] res_crc_reg, res_crc_next, tx_crc, calc_crc;
  logic [AW-1:0] rdata_reg, rdata_next;
  logic rd_ack_reg, rd_ack_next;
  logic stall_wr, wr_ok, tick, one, rcrc;
  logic [NW-1:0] tx_len, rx_len;
  logic [2*DW-1:0] rx_dat;
  logic [DW-1:0] got_a, got_b;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lane_a_sync_reg <= 2'h0;
      lane_b_sync_reg <= 2'h0;
    end else begin
      lane_a_sync_reg <= {lane_a_sync_reg[0], link.lane_a_out};
      lane_b_sync_reg <= {lane_b_sync_reg[0], link.lane_b_out};
    end
  end

  // Config and command are frozen while a frame runs
  assign stall_wr = avs_write_in & busy_reg
    & (avs_address_in == adcr_pkg::HOFF_CMD
    | avs_address_in == adcr_pkg::HOFF_CFG);
  assign wr_ok = avs_write_in & ~stall_wr;
  assign avs_waitrequest_out = stall_wr | (avs_read_in & ~rd_ack_reg);
  assign tick = div_reg == DIV_W'(HALF_CYC - 1);
  assign one = cfg_reg[adcr_pkg::C_ONE];
  assign rcrc = cfg_reg[adcr_pkg::C_RCRC];
  assign tx_len = cfg_reg[adcr_pkg::C_WCRC] ? NW'(RW) : NW'(DW);
  assign rx_len = (one ? NW'(2 * DW) : NW'(DW)) + (rcrc ? NW'(CW) : '0);
  assign rx_dat = rcrc ? rx_a_reg[TW-1:CW] : rx_a_reg[2*DW-1:0];
  assign got_a = one ? rx_dat[2*DW-1:DW] : rx_dat[DW-1:0];
  assign got_b = one ? rx_dat[DW-1:0] : rx_b_reg;

  adcr_crc #(.WIDTH(2 * DW)) u_tx_crc (
    .data_in({avs_writedata_in[DW-1:0], {DW{1'b0}}}),
    .crc_out(tx_crc)
  );

  adcr_crc #(.WIDTH(2 * DW)) u_rx_crc (
    .data_in({got_a, got_b}),
    .crc_out(calc_crc)
  );

  always_comb begin
    cfg_next = cfg_reg;
    mask_next = mask_reg;
    busy_next = busy_reg;
    cs_n_next = cs_n_reg;
    sclk_next = sclk_reg;
    div_next = div_reg;
    done_next = done_reg;
    len_next = len_reg;
    rxl_next = rxl_reg;
    tx_sr_next = tx_sr_reg;
    rx_a_next = rx_a_reg;
    rx_b_next = rx_b_reg;
    res_a_next = res_a_reg;
    res_b_next = res_b_reg;
    res_crc_next = res_crc_reg;
    cmd_next = cmd_reg;
    rdata_next = rdata_reg;
    st_set = '0;
    st_clr = '0;
    rd_ack_next = avs_read_in & ~rd_ack_reg;
    if (avs_read_in && !rd_ack_reg) begin
      case (avs_address_in)
        adcr_pkg::HOFF_CMD: rdata_next = AW'(cmd_reg);
        adcr_pkg::HOFF_CFG: rdata_next = AW'(cfg_reg);
        adcr_pkg::HOFF_RXA: rdata_next = AW'(res_a_reg);
        adcr_pkg::HOFF_RXB: rdata_next = AW'(res_b_reg);
        adcr_pkg::HOFF_RXCRC: rdata_next = AW'(res_crc_reg);
        adcr_pkg::HOFF_STATUS:
          rdata_next = AW'({busy_reg, {(adcr_pkg::ST_BUSY
            - adcr_pkg::ST_W){1'b0}}, status_reg});
        adcr_pkg::HOFF_MASK: rdata_next = AW'(mask_reg);
        default: rdata_next = '0;
      endcase
    end
    if (avs_read_in && rd_ack_reg
        && avs_address_in == adcr_pkg::HOFF_STATUS) begin
      st_clr = '1;
    end
    if (wr_ok) begin
      case (avs_address_in)
        adcr_pkg::HOFF_CMD: begin
          // Bit 15 of the command selects write, software composes it
          cmd_next = avs_writedata_in[DW-1:0];
          tx_sr_next = {avs_writedata_in[DW-1:0],
            cfg_reg[adcr_pkg::C_WCRC] ? tx_crc : {CW{1'b0}}};
          busy_next = 1'b1;
          cs_n_next = 1'b0;
          sclk_next = 1'b0;
          div_next = '0;
          done_next = '0;
          len_next = tx_len > rx_len ? tx_len : rx_len;
          rxl_next = rx_len;
          rx_a_next = '0;
          rx_b_next = '0;
        end
        adcr_pkg::HOFF_CFG:
          cfg_next = avs_writedata_in[adcr_pkg::CFG_W-1:0];
        adcr_pkg::HOFF_MASK:
          mask_next = avs_writedata_in[adcr_pkg::ST_W-1:0];
        default: cfg_next = cfg_reg;
      endcase
    end
    // A mask write in mid-frame must not stretch a link clock phase
    if (busy_reg) begin
      div_next = tick ? '0 : div_reg + DIV_W'(1);
      if (cs_n_reg) begin
        // Half a clock of idle select before the next frame
        if (tick) begin
          busy_next = 1'b0;
        end
      end else if (tick && !sclk_reg) begin
        sclk_next = 1'b1;
        if (done_reg < rxl_reg) begin
          rx_a_next = {rx_a_reg[TW-2:0], lane_a_sync_reg[1]};
        end
        if (done_reg < NW'(DW)) begin
          rx_b_next = {rx_b_reg[DW-2:0], lane_b_sync_reg[1]};
        end
        done_next = done_reg + NW'(1);
      end else if (tick) begin
        sclk_next = 1'b0;
        tx_sr_next = {tx_sr_reg[RW-2:0], 1'b0};
        if (done_reg == len_reg) begin
          cs_n_next = 1'b1;
          res_a_next = got_a;
          res_b_next = got_b;
          res_crc_next = rx_a_reg[CW-1:0];
          st_set[adcr_pkg::ST_DONE] = 1'b1;
          st_set[adcr_pkg::ST_CRCERR] = rcrc
            && calc_crc != rx_a_reg[CW-1:0];
        end
      end
    end
    status_next = (status_reg & ~st_clr) | st_set;
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg_reg <= '0;
      mask_reg <= '0;
      status_reg <= '0;
      busy_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      sclk_reg <= 1'b0;
      div_reg <= '0;
      done_reg <= '0;
      len_reg <= '0;
      rxl_reg <= '0;
      tx_sr_reg <= '0;
      rx_a_reg <= '0;
      rx_b_reg <= '0;
      res_a_reg <= '0;
      res_b_reg <= '0;
      res_crc_reg <= '0;
      cmd_reg <= '0;
      rdata_reg <= '0;
      rd_ack_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      mask_reg <= mask_next;
      status_reg <= status_next;
      busy_reg <= busy_next;
      cs_n_reg <= cs_n_next;
      sclk_reg <= sclk_next;
      div_reg <= div_next;
      done_reg <= done_next;
      len_reg <= len_next;
      rxl_reg <= rxl_next;
      tx_sr_reg <= tx_sr_next;
      rx_a_reg <= rx_a_next;
      rx_b_reg <= rx_b_next;
      res_a_reg <= res_a_next;
      res_b_reg <= res_b_next;
      res_crc_reg <= res_crc_next;
      cmd_reg <= cmd_next;
      rdata_reg <= rdata_next;
      rd_ack_reg <= rd_ack_next;
    end
  end

  assign avs_readdata_out = rdata_reg;
  assign irq_out = |(status_reg & mask_reg);
  assign link.cs_n = cs_n_reg;
  assign link.sclk = sclk_reg;
  assign link.sdi = tx_sr_reg[RW-1];
endmodule

// ---- dv/adcr_checker.sv ----
`timescale 1ns/100ps
module adcr_checker #(
  parameter int HALF_CYC = adcr_pkg::SCLK_HALF_CYC
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic lane_a_out,
  input wire logic lane_a_oe,
  input wire logic lane_b_out,
  input wire logic lane_b_oe
);
  logic [7:0] hi_reg;
  logic [7:0] hi_next;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  // Counts the high phase so the divider ratio is checked exactly
  always_comb begin
    hi_next = sclk ? hi_reg + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hi_reg <= 8'h00;
    end else begin
      hi_reg <= hi_next;
    end
  end
  AST_SCLK_HIGH: assert property ($fell(sclk) |-> hi_reg == HALF_CYC)
    else $error("link clock high phase has wrong length");
  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("link clock runs outside a frame");
  AST_START_GAP: assert property ($fell(cs_n) |-> !sclk [*5])
    else $error("link clock rises too soon after select");
  AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n [*2])
    else $error("frames too close together");
  AST_SDI_HOLD: assert property ($rose(sclk) |-> $stable(sdi) [*5])
    else $error("command line moved while clock high");
  AST_OE_ON: assert property ($fell(cs_n) |-> ##[1:6] lane_a_oe)
    else $error("lane a not driven in frame");
  AST_OE_OFF: assert property (
    cs_n [*6] |-> !lane_a_oe && !lane_b_oe)
    else $error("lane driven between frames");
  AST_LANE_A_HOLD: assert property (
    $rose(sclk) && !cs_n |-> $stable(lane_a_out) [*5])
    else $error("lane a moved while clock high");
  AST_LANE_B_HOLD: assert property (
    $rose(sclk) && lane_b_oe |-> $stable(lane_b_out) [*5])
    else $error("lane b moved while clock high");
endmodule

// ---- dv/adcr_tb_top.sv ----
`timescale 1ns/100ps
module adcr_tb_top;
  localparam int HC = 6;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [4:0] av_addr = 5'h00;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0;
  logic [31:0] av_rdata;
  logic av_wait;
  logic irq;
  logic [15:0] chan_a = 16'h0000;
  logic [15:0] chan_b = 16'h0000;
  logic [11:0] pcfg;
  logic [11:0] scfg;
  logic [39:0] lane_sh = 40'h0;
  logic [31:0] rv;
  int lane_bits = 0;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  adcr_link_if link();
  adcr_device u_adcr_device(.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .link(link), .chan_a_in(chan_a), .chan_b_in(chan_b),
    .primary_config_out(pcfg), .secondary_config_out(scfg));
  adcr_host #(.HALF_CYC(HC)) u_adcr_host(.clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in), .avs_address_in(av_addr), .avs_read_in(av_rd),
    .avs_write_in(av_wr), .avs_writedata_in(av_wdata),
    .avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait),
    .irq_out(irq), .link(link));
  adcr_checker #(.HALF_CYC(HC)) u_adcr_checker(.clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in), .cs_n(link.cs_n), .sclk(link.sclk),
    .sdi(link.sdi), .lane_a_out(link.lane_a_out),
    .lane_a_oe(link.lane_a_oe), .lane_b_out(link.lane_b_out),
    .lane_b_oe(link.lane_b_oe));
  always #4 clk_sys_in = ~clk_sys_in;
  // Lane a as the wire shows it, taken at link clock rise
  always @(negedge link.cs_n) lane_bits = 0;
  always @(posedge link.sclk) begin
    if (!link.cs_n) begin
      lane_sh = {lane_sh[38:0], link.lane_a_out};
      lane_bits++;
    end
  end
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [39:0] s,
    input logic [39:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [39:0] v;
    v = {d[31:24] ^ 8'hff, d[23:0], 8'h00};
    for (int i = 39; i >= 8; i--) begin
      if (v[i]) begin
        v[i-:9] = v[i-:9] ^ 9'h107;
      end
    end
    return v[7:0];
  endfunction
  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [31:0] d);
    @(posedge clk_sys_in);
    av_addr <= a;
    av_wr <= w;
    av_rd <= !w;
    av_wdata <= d;
    @(posedge clk_sys_in);
    while (av_wait !== 1'b0) begin
      @(posedge clk_sys_in);
    end
    rv = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic frame(input logic [15:0] c);
    bus(1'b1, adcr_pkg::HOFF_CMD, {16'h0, c});
    wait (link.cs_n === 1'b0);
    wait (link.cs_n === 1'b1);
    repeat (8) @(posedge clk_sys_in);
  endtask
  task automatic rdreg(input logic [2:0] a, input logic [11:0] e);
    frame({1'b0, a, 12'h000});
    frame(16'h0000);
    rd(adcr_pkg::HOFF_RXA);
    check("readback", 40'(rv[15:0]), 40'({1'b0, a, e}));
    rd(adcr_pkg::HOFF_RXB);
    check("readback b", 40'(rv[15:0]), 40'h0);
  endtask
  task automatic t_regs();
    check("config outs", 40'({pcfg, scfg}), 40'h0);
    rdreg(3'h1, 12'h000);
    rdreg(3'h5, 12'hfff);
    rdreg(3'h4, 12'h000);
    rdreg(3'h3, 12'h000);
    frame({1'b1, 3'h3, 12'hfff});
    frame({1'b1, 3'h6, 12'hfff});
    frame({1'b1, 3'h0, 12'hfff});
    check("config outs", 40'({pcfg, scfg}), 40'h0);
    rdreg(3'h3, 12'h000);
    frame({1'b1, 3'h4, 12'h123});
    frame({1'b1, 3'h5, 12'h9ab});
    rdreg(3'h4, 12'h123);
    rdreg(3'h5, 12'h9ab);
    // A over the upper limit, B under the lower one
    frame({1'b1, 3'h1, 12'h008});
    chan_a <= 16'hf000;
    chan_b <= 16'h0000;
    frame(16'h0000);
    frame({1'b1, 3'h1, 12'h000});
    rdreg(3'h3, 12'h012);
  endtask
  task automatic t_undef();
    logic [2:0] a;
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 3'h0 : 3'(i + 5);
      chan_a <= 16'h1230 + 16'(i);
      chan_b <= 16'h8765;
      frame({1'b0, a, 12'h000});
      chan_a <= 16'hffff;
      frame(16'h0000);
      rd(adcr_pkg::HOFF_RXA);
      check("undef a", 40'(rv[15:0]), 40'(16'h1230 + 16'(i)));
      rd(adcr_pkg::HOFF_RXB);
      check("undef b", 40'(rv[15:0]), 40'h8765);
    end
  endtask
  task automatic t_crc();
    logic [31:0] v [3];
    logic [39:0] e;
    v = '{32'h00000000, 32'hffffffff, 32'h12345678};
    frame({1'b1, 3'h1, 12'h010});
    bus(1'b1, adcr_pkg::HOFF_CFG, 32'h2);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        frame({1'b1, 3'h2, 12'h100});
        bus(1'b1, adcr_pkg::HOFF_CFG, 32'h6);
      end
      {chan_a, chan_b} <= v[i % 3];
      frame(16'h0000);
      frame(16'h0000);
      e = {v[i % 3], crc8(v[i % 3])};
      rd(adcr_pkg::HOFF_RXCRC);
      check("crc", 40'(rv[7:0]), 40'(e[7:0]));
      if (i == 3) begin
        check("one lane", lane_sh, e);
      end else begin
        check("lane a", 40'(lane_sh[23:0]), 40'({e[39:24], e[7:0]}));
      end
      check("bits", 40'(lane_bits), (i == 3) ? 40'h28 : 40'h18);
    end
    frame({1'b0, 3'h1, 12'h000});
    frame(16'h0000);
    rd(adcr_pkg::HOFF_RXCRC);
    check("reg crc", 40'(rv[7:0]), 40'(crc8(32'h10100000)));
    frame({1'b1, 3'h2, 12'h000});
    frame({1'b1, 3'h1, 12'h000});
    bus(1'b1, adcr_pkg::HOFF_CFG, 32'h0);
  endtask
  task automatic t_wcrc();
    bus(1'b1, adcr_pkg::HOFF_CFG, 32'h1);
    frame({1'b1, 3'h1, 12'h020});
    check("wcrc on", 40'(pcfg), 40'h020);
    bus(1'b1, adcr_pkg::HOFF_CFG, 32'h0);
    frame({1'b1, 3'h1, 12'h000});
    check("no check byte", 40'(pcfg), 40'h020);
    rdreg(3'h3, 12'h200);
    bus(1'b1, adcr_pkg::HOFF_CFG, 32'h1);
    frame({1'b1, 3'h1, 12'h000});
    check("wcrc off", 40'(pcfg), 40'h000);
    bus(1'b1, adcr_pkg::HOFF_CFG, 32'h0);
  endtask
  task automatic t_irq();
    bus(1'b1, adcr_pkg::HOFF_MASK, 32'h1);
    rd(adcr_pkg::HOFF_STATUS);
    frame(16'h0000);
    @(negedge clk_sys_in);
    check("irq set", 40'(irq), 40'h1);
    rd(adcr_pkg::HOFF_STATUS);
    check("status", 40'(rv[1:0]), 40'h1);
    @(negedge clk_sys_in);
    check("irq clear", 40'(irq), 40'h0);
    bus(1'b1, adcr_pkg::HOFF_MASK, 32'h0);
    frame(16'h0000);
    @(negedge clk_sys_in);
    check("irq masked", 40'(irq), 40'h0);
    rd(5'h1c);
    check("unmapped", 40'(rv), 40'h0);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    t_regs();
    t_undef();
    t_crc();
    t_wcrc();
    t_irq();
    end_sim();
  end
endmodule
